// *** ahci_ccc_counter.sv ***
/*
 command completion coalescing counter.
 assumes completions arrive as a per-cycle count and the clear comes from
 the threshold compare in this counter, against the parent's threshold.
*/
`timescale 1ns/1ns
`default_nettype none
module ahci_ccc_counter
    import ahci_fix_pkg::*;
#(
    parameter int WIDTH = CCC_COUNT_WIDTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic enable,
    input wire logic [WIDTH-1:0] increment,
    input wire logic [WIDTH-1:0] threshold,
    // result
    output logic [WIDTH-1:0] count,
    output logic fire
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic fire;
    } ccc_s;

    ccc_s state;
    ccc_s next_state;
    logic [WIDTH:0] sum;

    always_comb
    begin
        next_state = state;
        sum = {1'b0, state.count} + {1'b0, increment};
        next_state.fire = 1'b0;
        if (!enable)
        begin
            next_state.count = WIDTH'(CCC_COUNT_RESET);
        end
        else if (threshold != '0 && sum >= {1'b0, threshold})
        begin
            // extra completions in the clearing cycle ride on this interrupt
            next_state.count = WIDTH'(CCC_COUNT_RESET);
            next_state.fire = 1'b1;
        end
        else
        begin
            next_state.count = sum[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign count = state.count;
    assign fire = state.fire;

    count_clears_a: assert property (@(posedge clk) disable iff (reset)
        fire |-> count == '0)
        else $error("count not zero when coalescing interrupt fires");
    count_grows_a: assert property (@(posedge clk) disable iff (reset)
        enable && !fire && $past(enable) |-> count >= $past(count))
        else $error("coalescing count went backwards without firing");
    cover property (@(posedge clk) disable iff (reset) fire);
endmodule
`default_nettype wire

// *** ahci_fix_core.sv ***
/*
 corrected ahci host behaviour: reset and interrupt summary, coalescing,
 descriptor-done timing, phy power requests, tx fifo clear, soft reset.
 assumes all inputs synchronous to clk; one port dma and link per port slice.
*/
// What this block does
// - tx data beats slumber request; send xrdy
// - successful partial raises only light-sleep request
// - never both phy sleep requests together
// - clear colliding with increments ends at zero
// - each cleared sact bit advances coalescing count
// - descriptor done only after all its data
// - cominit during rx or comreset clears tx fifo
// - write response exactly one cycle per write
// - dma advances when register frame response returns
// - soft reset: still answer xrdy, drop strobes
// - host interrupt needs enable and pending bit
// - phy-ready loss in non-data frame sets error
`timescale 1ns/1ns
`default_nettype none
module ahci_fix_core
    import ahci_fix_pkg::*;
#(
    parameter int PORTS = NUM_PORTS,
    parameter int CW = CCC_COUNT_WIDTH,
    parameter int XW = XFER_WIDTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // global control and interrupt summary
    input wire logic global_reset_req,
    input wire logic global_int_enable,
    input wire logic [PORTS-1:0] port_int_pending,
    input wire logic [PORTS-1:0] pending_clear,
    output logic [PORTS-1:0] pending_summary,
    output logic host_interrupt,
    // completion coalescing
    input wire logic ccc_enable,
    input wire logic [CW-1:0] ccc_threshold,
    input wire logic sdb_frame_valid,
    input wire logic [SACT_WIDTH-1:0] sact_cleared,
    output logic [CW-1:0] ccc_count,
    output logic ccc_interrupt,
    // descriptor progress
    input wire logic prd_start,
    input wire logic [XW-1:0] prd_length,
    input wire logic data_beat,
    output logic prd_done_interrupt,
    // power management
    input wire logic rx_slumber_req,
    input wire logic rx_partial_req,
    input wire logic sw_slumber_req,
    input wire logic sw_partial_req,
    input wire logic pm_nak,
    input wire logic pm_ack,
    input wire logic tx_payload_ready,
    output logic phy_light_sleep,
    output logic phy_deep_sleep,
    output logic tx_send_xrdy,
    // link events and fifo
    input wire logic rx_cominit,
    input wire logic comreset,
    input wire logic rx_data_active,
    input wire logic tx_fifo_almost_full,
    input wire logic mem_write_done,
    output logic tx_fifo_clear,
    output logic dma_write_response,
    // register frame posting
    input wire logic d2h_frame_posted,
    output logic dma_advance,
    // soft reset and rx strobes
    input wire logic soft_reset_req,
    input wire logic rx_xrdy,
    input wire logic link_first_word,
    input wire logic link_valid,
    input wire logic rx_nondata_frame,
    input wire logic phy_ready,
    output logic tx_send_rrdy,
    output logic rx_first_word,
    output logic rx_valid,
    output logic if_nonfatal_error
);
    typedef struct packed {
        logic [PORTS-1:0] pending;
        logic irq;
        logic [XW-1:0] prd_left;
        logic prd_busy;
        logic prd_done;
        pm_state_e pm;
        logic light;
        logic deep;
        logic xrdy;
        logic fifo_clear;
        logic wr_resp;
        logic wait_resp;
        logic advance;
        logic rrdy;
        logic first;
        logic valid;
        logic srst;
        logic err;
    } core_s;

    core_s state;
    core_s next_state;
    logic [CW-1:0] completions;
    logic ccc_fire;

    // population count of cleared tags, clipped to counter width
    function automatic logic [CW-1:0] popcount(input logic [SACT_WIDTH-1:0] v);
        logic [CW-1:0] n;
        n = '0;
        for (int i = 0; i < SACT_WIDTH; i++)
        begin
            n = n + CW'(v[i]);
        end
        return n;
    endfunction

    assign completions = sdb_frame_valid ? popcount(sact_cleared) : '0;

    ahci_ccc_counter #(
        .WIDTH(CW)
    ) ccc (
        .clk(clk),
        .reset(reset),
        .enable(ccc_enable),
        .increment(completions),
        .threshold(ccc_threshold),
        .count(ccc_count),
        .fire(ccc_fire)
    );

    always_comb
    begin
        next_state = state;
        // interrupt summary: hardware set wins over software clear
        if (global_reset_req)
        begin
            next_state.pending = '0;
        end
        else
        begin
            next_state.pending = (state.pending & ~pending_clear) | port_int_pending;
        end
        next_state.irq = global_int_enable && (next_state.pending != '0);

        // descriptor done fires on the last beat, not the first frame
        next_state.prd_done = 1'b0;
        if (prd_start)
        begin
            next_state.prd_left = prd_length;
            next_state.prd_busy = prd_length != '0;
        end
        else if (state.prd_busy && data_beat)
        begin
            next_state.prd_left = state.prd_left - XW'(1);
            if (state.prd_left == XW'(1))
            begin
                next_state.prd_busy = 1'b0;
                next_state.prd_done = 1'b1;
            end
        end

        // power negotiation; outgoing data always beats a slumber request
        next_state.xrdy = 1'b0;
        unique case (state.pm)
            PM_ACTIVE:
            begin
                if (rx_slumber_req && tx_payload_ready)
                begin
                    next_state.xrdy = 1'b1;
                end
                else if (rx_partial_req)
                begin
                    // device partial wins a collision with software slumber
                    next_state.pm = PM_PARTIAL_NEG;
                end
                else if (rx_slumber_req || sw_slumber_req)
                begin
                    next_state.pm = PM_SLUMBER_NEG;
                end
                else if (sw_partial_req)
                begin
                    next_state.pm = PM_PARTIAL_NEG;
                end
            end
            PM_PARTIAL_NEG, PM_SLUMBER_NEG:
            begin
                if (pm_nak || tx_payload_ready)
                begin
                    next_state.pm = PM_ACTIVE;
                end
                else if (pm_ack)
                begin
                    next_state.pm = (state.pm == PM_PARTIAL_NEG) ? PM_PARTIAL : PM_SLUMBER;
                end
            end
            PM_PARTIAL, PM_SLUMBER:
            begin
                if (tx_payload_ready || !phy_ready)
                begin
                    next_state.pm = PM_ACTIVE;
                end
            end
            default:
            begin
                next_state.pm = PM_ACTIVE;
            end
        endcase
        // outputs decoded from one state, so never both at once
        next_state.light = next_state.pm == PM_PARTIAL;
        next_state.deep = next_state.pm == PM_SLUMBER;

        // fifo clear and single-cycle write response
        next_state.fifo_clear = (rx_cominit && rx_data_active) || comreset;
        // almost-full during clear must not stretch the response
        next_state.wr_resp = mem_write_done;

        // register frame posting waits for its own write response
        next_state.advance = 1'b0;
        if (d2h_frame_posted)
        begin
            next_state.wait_resp = 1'b1;
        end
        else if (state.wait_resp && state.wr_resp)
        begin
            next_state.wait_resp = 1'b0;
            next_state.advance = 1'b1;
        end

        // soft reset: answer xrdy, gate frame strobes
        next_state.srst = soft_reset_req;
        next_state.rrdy = rx_xrdy;
        next_state.first = link_first_word && !soft_reset_req && !state.srst;
        next_state.valid = link_valid && !soft_reset_req && !state.srst;

        // error is sticky until reset
        if (rx_nondata_frame && !phy_ready)
        begin
            next_state.err = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pending_summary = state.pending;
    assign host_interrupt = state.irq;
    assign ccc_interrupt = ccc_fire;
    assign prd_done_interrupt = state.prd_done;
    assign phy_light_sleep = state.light;
    assign phy_deep_sleep = state.deep;
    assign tx_send_xrdy = state.xrdy;
    assign tx_fifo_clear = state.fifo_clear;
    assign dma_write_response = state.wr_resp;
    assign dma_advance = state.advance;
    assign tx_send_rrdy = state.rrdy;
    assign rx_first_word = state.first;
    assign rx_valid = state.valid;
    assign if_nonfatal_error = state.err;

    sleep_exclusive_a: assert property (@(posedge clk) disable iff (reset)
        !(phy_light_sleep && phy_deep_sleep))
        else $error("both phy sleep requests active");
    reset_clears_pending_a: assert property (@(posedge clk) disable iff (reset)
        global_reset_req |=> pending_summary == '0)
        else $error("pending summary survived global reset");
    irq_gated_a: assert property (@(posedge clk) disable iff (reset)
        host_interrupt |-> $past(global_int_enable) && pending_summary != '0)
        else $error("interrupt without enable or pending bit");
    wr_resp_single_a: assert property (@(posedge clk) disable iff (reset)
        !mem_write_done |=> !dma_write_response)
        else $error("write response stretched");
    // almost-full once dropped the ready and bent the response
    resp_full_a: assert property (@(posedge clk) disable iff (reset)
        mem_write_done && tx_fifo_almost_full |=> dma_write_response)
        else $error("write response lost while fifo almost full");
    xrdy_collision_a: assert property (@(posedge clk) disable iff (reset)
        state.pm == PM_ACTIVE && rx_slumber_req && tx_payload_ready
        |=> tx_send_xrdy && !phy_deep_sleep)
        else $error("slumber not refused against tx data");
    partial_light_a: assert property (@(posedge clk) disable iff (reset)
        state.pm == PM_PARTIAL_NEG && pm_ack && !pm_nak && !tx_payload_ready
        |=> phy_light_sleep && !phy_deep_sleep)
        else $error("partial did not raise light sleep only");
    fifo_clear_a: assert property (@(posedge clk) disable iff (reset)
        comreset |=> tx_fifo_clear)
        else $error("comreset did not clear tx fifo");
    srst_strobes_a: assert property (@(posedge clk) disable iff (reset)
        soft_reset_req |=> !rx_first_word && !rx_valid ##1 !rx_first_word)
        else $error("frame strobes after soft reset");
    rrdy_answer_a: assert property (@(posedge clk) disable iff (reset)
        rx_xrdy |=> tx_send_rrdy)
        else $error("xrdy not answered");
    prd_done_late_a: assert property (@(posedge clk) disable iff (reset)
        prd_done_interrupt |-> $past(data_beat) && $past(state.prd_left) == XW'(1))
        else $error("descriptor done before last beat");
    advance_resp_a: assert property (@(posedge clk) disable iff (reset)
        dma_advance |-> $past(dma_write_response))
        else $error("dma advanced without response");
    error_set_a: assert property (@(posedge clk) disable iff (reset)
        rx_nondata_frame && !phy_ready |=> if_nonfatal_error)
        else $error("phy loss in non-data frame not flagged");

    cover property (@(posedge clk) disable iff (reset) phy_light_sleep);
    cover property (@(posedge clk) disable iff (reset) prd_done_interrupt);
    cover property (@(posedge clk) disable iff (reset) dma_advance);
    cover property (@(posedge clk) disable iff (reset) host_interrupt);
endmodule
`default_nettype wire

// *** ahci_fix_pkg.sv ***
/*
 package of constants for the corrected ahci host behaviour block.
 assumes a single 20 MHz clock domain and a synchronous active-high reset.
*/
package ahci_fix_pkg;
    localparam int NUM_PORTS = 4;
    localparam int CCC_COUNT_WIDTH = 8;
    localparam int SACT_WIDTH = 32;
    localparam int XFER_WIDTH = 16;
    localparam logic [7:0] CCC_COUNT_RESET = 8'h00;
    localparam logic [7:0] CCC_THRESHOLD_RESET = 8'h04;

    // power-mode negotiation states
    typedef enum logic [2:0] {
        PM_ACTIVE = 3'b000,
        PM_PARTIAL_NEG = 3'b001,
        PM_SLUMBER_NEG = 3'b010,
        PM_PARTIAL = 3'b011,
        PM_SLUMBER = 3'b100
    } pm_state_e;

    // link idle, receive and transmit states
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_RX_FRAME = 2'b01,
        LK_TX_FRAME = 2'b10
    } link_state_e;
endpackage

// *** sata_ahci_host_pm_intr_test.sv ***
/*
 self-checking bench for the corrected ahci behaviour block.
 assumes sata_dev_model on the link side and a 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sata_ahci_host_pm_intr_test import ahci_fix_pkg::*; ();
    logic clk = 1'h0, reset = 1'h1, global_reset_req = 1'h0, global_int_enable = 1'h0;
    logic [3:0] port_int_pending = 4'h0, pending_clear = 4'h0, pv, pending_summary;
    logic ccc_enable = 1'h0, sdb_frame_valid = 1'h0, prd_start = 1'h0, data_beat = 1'h0;
    logic [7:0] ccc_threshold = 8'h00, ccc_count;
    logic [31:0] sact_cleared = 32'h0, sact;
    logic [15:0] prd_length = 16'h0;
    logic sw_slumber_req = 1'h0, sw_partial_req = 1'h0, pm_nak = 1'h0, tx_payload_ready = 1'h0;
    logic rx_cominit = 1'h0, comreset = 1'h0, rx_data_active = 1'h0, tx_fifo_almost_full = 1'h0;
    logic mem_write_done = 1'h0, d2h_frame_posted = 1'h0, soft_reset_req = 1'h0;
    logic rx_nondata_frame = 1'h0, phy_ready = 1'h1;
    logic go_partial = 1'h0, go_slumber = 1'h0, go_frame = 1'h0, go_ack = 1'h0;
    logic rx_slumber_req, rx_partial_req, pm_ack, rx_xrdy, link_first_word, link_valid;
    logic host_interrupt, ccc_interrupt, prd_done_interrupt, phy_light_sleep, phy_deep_sleep;
    logic tx_send_xrdy, tx_fifo_clear, dma_write_response, dma_advance, tx_send_rrdy;
    logic rx_first_word, rx_valid, if_nonfatal_error;
    int n_errors = 0, total_checks = 0, cyc = 0, acc, i, seen_rrdy, seen_strobe;
    // expected cycle of each pulse: ccc, prd done, write response, advance
    int exp_q[4][$];

    ahci_fix_core ahci_fix_core_i (.clk, .reset, .global_reset_req, .global_int_enable,
        .port_int_pending, .pending_clear, .pending_summary, .host_interrupt, .ccc_enable,
        .ccc_threshold, .sdb_frame_valid, .sact_cleared, .ccc_count, .ccc_interrupt,
        .prd_start, .prd_length, .data_beat, .prd_done_interrupt, .rx_slumber_req,
        .rx_partial_req, .sw_slumber_req, .sw_partial_req, .pm_nak, .pm_ack,
        .tx_payload_ready, .phy_light_sleep, .phy_deep_sleep, .tx_send_xrdy, .rx_cominit,
        .comreset, .rx_data_active, .tx_fifo_almost_full, .mem_write_done, .tx_fifo_clear,
        .dma_write_response, .d2h_frame_posted, .dma_advance, .soft_reset_req, .rx_xrdy,
        .link_first_word, .link_valid, .rx_nondata_frame, .phy_ready, .tx_send_rrdy,
        .rx_first_word, .rx_valid, .if_nonfatal_error);
    sata_dev_model sata_dev_model_i (.clk, .reset, .go_partial, .go_slumber, .go_frame, .go_ack,
        .tx_send_xrdy, .rx_partial_req, .rx_slumber_req, .pm_ack, .rx_xrdy,
        .link_first_word, .link_valid);

    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic bad(input string m);
        n_errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
            bad("level differs");
    endtask
    task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
            bad("count differs");
    endtask
    // the coalescing pulse may come one cycle after its expected cycle
    task automatic chk_pulse(input int k);
        int e;
        total_checks++;
        e = (exp_q[k].size() > 0) ? exp_q[k].pop_front() : -9;
        if (cyc < e || cyc > e + (k == 0))
            bad("pulse off time");
    endtask
    task automatic wait_hi(input int w);
        int t;
        for (t = 0; t < 20 && (w == 0 ? tx_send_xrdy : phy_light_sleep) !== 1'h1; t++)
            tick();
        if (t == 20)
        begin
            bad("wait ran out");
            report_and_stop();
        end
    endtask

    always @(posedge clk)
    begin
        #5;
        if (ccc_interrupt === 1'h1)
            chk_pulse(0);
        if (prd_done_interrupt === 1'h1)
            chk_pulse(1);
        if (dma_write_response === 1'h1)
            chk_pulse(2);
        if (dma_advance === 1'h1)
            chk_pulse(3);
    end

    initial
    begin
        void'($urandom(32'h1126));
        tick(2);
        reset = 1'h0;
        chk_bit(if_nonfatal_error, 1'h0);
        pv = 4'h1 | 4'($urandom);
        port_int_pending = pv;
        global_int_enable = 1'h1;
        tick();
        port_int_pending = 4'h0;
        chk_bit(host_interrupt, 1'h1);
        chk_bit(pending_summary == pv, 1'h1);
        global_int_enable = 1'h0;
        tick(2);
        chk_bit(host_interrupt, 1'h0);
        global_reset_req = 1'h1;
        tick();
        global_reset_req = 1'h0;
        global_int_enable = 1'h1;
        tick(2);
        chk_bit(pending_summary == 4'h0, 1'h1);
        chk_bit(host_interrupt, 1'h0);
        port_int_pending = pv;
        tick();
        port_int_pending = 4'h0;
        pending_clear = 4'hF;
        tick(2);
        pending_clear = 4'h0;
        chk_bit(host_interrupt | (|pending_summary), 1'h0);
        ccc_threshold = 8'h04;
        ccc_enable = 1'h1;
        acc = 0;
        for (i = 0; i < 12; i++)
        begin
            sact = 32'($urandom % 8) << ($urandom % 29);
            sact_cleared = sact;
            sdb_frame_valid = 1'h1;
            acc = acc + $countones(sact);
            if (acc >= 4)
            begin
                acc = 0;
                exp_q[0].push_back(cyc + 1);
            end
            tick();
            sdb_frame_valid = 1'h0;
            tick(3);
            chk_cnt(ccc_count, 8'(acc));
        end
        prd_length = 16'(2 + $urandom % 4);
        prd_start = 1'h1;
        tick();
        prd_start = 1'h0;
        // gaps split the descriptor over several frames
        for (i = 0; i < prd_length; i++)
        begin
            data_beat = 1'h1;
            if (i == prd_length - 1)
                exp_q[1].push_back(cyc + 1);
            tick();
            data_beat = 1'h0;
            tick(2);
        end
        rx_data_active = 1'h1;
        {rx_cominit, mem_write_done, tx_fifo_almost_full} = 3'h7;
        exp_q[2].push_back(cyc + 1);
        tick();
        {rx_cominit, mem_write_done, tx_fifo_almost_full} = 3'h0;
        chk_bit(tx_fifo_clear, 1'h1);
        tick(2);
        comreset = 1'h1;
        tick();
        comreset = 1'h0;
        chk_bit(tx_fifo_clear, 1'h1);
        tick(2);
        d2h_frame_posted = 1'h1;
        tick();
        d2h_frame_posted = 1'h0;
        mem_write_done = 1'h1;
        exp_q[2].push_back(cyc + 1);
        exp_q[3].push_back(cyc + 2);
        tick();
        mem_write_done = 1'h0;
        tick(4);
        tx_payload_ready = 1'h1;
        go_slumber = 1'h1;
        tick();
        go_slumber = 1'h0;
        wait_hi(0);
        chk_bit(phy_deep_sleep | phy_light_sleep, 1'h0);
        tick(4);
        tx_payload_ready = 1'h0;
        go_partial = 1'h1;
        tick();
        go_partial = 1'h0;
        wait_hi(1);
        chk_bit(phy_deep_sleep, 1'h0);
        tx_payload_ready = 1'h1;
        tick(3);
        tx_payload_ready = 1'h0;
        chk_bit(phy_light_sleep, 1'h0);
        go_partial = 1'h1;
        tick();
        go_partial = 1'h0;
        sw_slumber_req = 1'h1;
        tick(2);
        sw_slumber_req = 1'h0;
        wait_hi(1);
        chk_bit(phy_deep_sleep, 1'h0);
        tx_payload_ready = 1'h1;
        tick(3);
        tx_payload_ready = 1'h0;
        // software slumber alone must raise deep sleep only
        sw_slumber_req = 1'h1;
        tick();
        sw_slumber_req = 1'h0;
        go_ack = 1'h1;
        tick();
        go_ack = 1'h0;
        tick();
        chk_bit(phy_deep_sleep, 1'h1);
        chk_bit(phy_light_sleep, 1'h0);
        phy_ready = 1'h0;
        tick(2);
        phy_ready = 1'h1;
        chk_bit(phy_deep_sleep, 1'h0);
        // refused partial must never reach light sleep
        sw_partial_req = 1'h1;
        tick();
        sw_partial_req = 1'h0;
        pm_nak = 1'h1;
        go_ack = 1'h1;
        tick();
        {pm_nak, go_ack} = 2'h0;
        tick(2);
        chk_bit(phy_light_sleep, 1'h0);
        for (i = 0; i < 2; i++)
        begin
            soft_reset_req = 1'(i);
            go_frame = 1'h1;
            seen_rrdy = 0;
            seen_strobe = 0;
            tick();
            go_frame = 1'h0;
            repeat (6)
            begin
                tick();
                seen_rrdy |= (tx_send_rrdy === 1'h1);
                seen_strobe |= (rx_valid === 1'h1) || (rx_first_word === 1'h1);
            end
            chk_bit(seen_rrdy == 1, 1'h1);
            chk_bit(seen_strobe == 1, i == 0);
        end
        soft_reset_req = 1'h0;
        rx_nondata_frame = 1'h1;
        phy_ready = 1'h0;
        tick();
        {rx_nondata_frame, phy_ready} = 2'h1;
        chk_bit(if_nonfatal_error, 1'h1);
        tick(4);
        for (i = 0; i < 4; i++)
            chk_bit(exp_q[i].size() == 0, 1'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** sata_dev_model.sv ***
/*
 sata device model on the far side of the corrected ahci block.
 assumes one-cycle commands from the bench, sampled on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module sata_dev_model
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // commands from the bench
    input wire logic go_partial,
    input wire logic go_slumber,
    input wire logic go_frame,
    input wire logic go_ack,
    // host answer
    input wire logic tx_send_xrdy,
    // device side
    output logic rx_partial_req,
    output logic rx_slumber_req,
    output logic pm_ack,
    output logic rx_xrdy,
    output logic link_first_word,
    output logic link_valid
);
    logic [1:0] frame_step;
    always @(posedge clk)
    begin
        if (reset)
        begin
            {rx_partial_req, rx_slumber_req, pm_ack, rx_xrdy} <= 4'h0;
            {link_first_word, link_valid, frame_step} <= 4'h0;
        end
        else
        begin
            rx_partial_req <= go_partial;
            // acks at once; a slow ack is not modelled
            // host-initiated requests are acked on the bench's command
            pm_ack <= rx_partial_req | go_ack;
            // request held until the host answers with xrdy
            rx_slumber_req <= go_slumber | (rx_slumber_req & ~tx_send_xrdy);
            frame_step <= {frame_step[0], go_frame};
            rx_xrdy <= go_frame;
            link_first_word <= frame_step[0];
            link_valid <= |frame_step;
        end
    end
endmodule
`default_nettype wire
